/* File: hdl/watchdog_power_reset_control.sv */
// Watchdog, power management and reset control with Avalon-MM registers
// Behaviour
// - Watchdog runs only while enable bit set
// - Clear bit resets counter, prescaler, itself
// - Idle halts watchdog unless run-in-idle set
// - Prescale field selects divide two to 256
// - Timeout is 12 osc times 2^14 times ratio
// - Enabled watchdog timeout forces system reset
// - Any reset disables and clears the watchdog
// - Oscillator divided by two internally
// - Idle stops processor clock, peripherals run
// - Enabled interrupt or reset ends idle
// - Power-down stops all clocks; reset exits
// - Reset sampled once per cycle, two cycles; every osc period in power-down
// - Short reset pin glitches are ignored
// - Reset loads documented register reset values
// - Power-on reset sets power-on flag
// - Two free general-purpose flags in power control
//
// The Avalon-MM interface to the registers is this design's own decision.
module watchdog_power_reset_control
	import wdt_pm_pkg::*;
#(
	parameter int PRESC_W = 8
)
(
	// Clock and reset
	input  wire  logic                      ref_clk,
	input  wire  logic                      rst_b,
	// External reset pin, asynchronous
	input  wire  logic                      reset_pin,
	// Wake request from enabled interrupts
	input  wire  logic                      wake_irq,
	// Avalon-MM slave
	input  wire  logic [wdt_pm_pkg::ADDR_W-1:0] avs_address,
	input  wire  logic                      avs_read,
	input  wire  logic                      avs_write,
	input  wire  logic [3:0]                avs_byteenable,
	input  wire  logic [31:0]               avs_writedata,
	output logic       [31:0]               avs_readdata,
	output logic                            avs_waitrequest,
	output logic       [1:0]                avs_response,
	// Clock gating and reset outputs
	output logic                            core_clk_en,
	output logic                            periph_clk_en,
	output logic                            osc_run,
	output logic                            sys_reset,
	output logic       [7:0]                port_reset_val,
	output logic       [7:0]                sp_reset_val,
	output logic       [7:0]                sfr_reset_val,
	// Interrupt
	output logic                            irq
);
	import wdt_pm_pkg::*;

	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_IDLE  = 3'b010,
		MODE_POWDN = 3'b100
	} mode_type;

	// Prescale ratio exponent from the field (ratio = 2**n)
	function automatic logic [3:0] presc_exp(input logic [2:0] sel);
		unique case (sel)
			3'b000:  presc_exp = 4'h1;
			3'b010:  presc_exp = 4'h2;
			3'b001:  presc_exp = 4'h3;
			3'b011:  presc_exp = 4'h4;
			3'b100:  presc_exp = 4'h5;
			3'b101:  presc_exp = 4'h6;
			3'b110:  presc_exp = 4'h7;
			default: presc_exp = 4'h8;
		endcase
	endfunction : presc_exp

	mode_type          mode_q;
	logic [7:0]        pwr_ctl_q;
	logic [7:0]        wd_ctl_q;
	logic [EV_W-1:0]   irq_st_q;
	logic [EV_W-1:0]   irq_mk_q;
	logic              osc_half_q;
	logic [3:0]        mc_cnt_q;
	logic              mc_tick;
	logic              pin_s1_q;
	logic              pin_s2_q;
	logic [1:0]        pin_hold_q;
	logic              pin_rst;
	logic [WDT_BITS-1:0] wdt_cnt_q;
	logic [PRESC_W-1:0] presc_q;
	logic              presc_tick;
	logic              wdt_run;
	logic              wdt_timeout;
	logic [4:0]        srst_cnt_q;
	logic              srst_req;
	logic              por_done_q;
	logic              wd_clear_pend_q;
	logic              wr_pwr_ctl;
	logic              wr_wd_ctl;
	logic              rd_ack_q;
	logic [31:0]       rd_mux;
	logic              wr_st;
	logic              wr_mk;
	logic              wake_ev;
	logic [EV_W-1:0]   ev_set;
	logic              mapped;

	// Divide by two first, then six core ticks per machine cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			osc_half_q <= 1'b0;
		else if (mode_q != MODE_POWDN)
			osc_half_q <= ~osc_half_q;
	end

	// Machine-cycle counter; twelve oscillator periods per cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			mc_cnt_q <= 4'h0;
		else if (mode_q != MODE_POWDN && osc_half_q)
			mc_cnt_q <= (mc_cnt_q == 4'(OSC_PER_MC / CORE_DIV - 1)) ? 4'h0 : mc_cnt_q + 4'h1;
	end
	assign mc_tick = osc_half_q && (mc_cnt_q == 4'(OSC_PER_MC / CORE_DIV - 1))
		&& (mode_q != MODE_POWDN);

	// Reset pin synchroniser; only the second stage is read
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= reset_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Sampled at one phase per machine cycle; pin sampling runs even in
	// power-down since the pin is the only exit from it
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_hold_q <= 2'b00;
		else if (osc_half_q && mc_cnt_q == 4'(RST_PHASE / CORE_DIV - 4) || mode_q == MODE_POWDN)
		begin
			// A single low sample restarts the count; a glitch between samples is not seen
			if (!pin_s2_q)
				pin_hold_q <= 2'b00;
			else if (pin_hold_q != 2'(RST_HOLD_MC))
				pin_hold_q <= pin_hold_q + 2'b01;
		end
	end
	assign pin_rst = (pin_hold_q == 2'(RST_HOLD_MC));

	// Bus decode
	assign mapped  = avs_address == PWR_CTL_ADDR || avs_address == WD_CTL_ADDR
		|| avs_address == IRQ_ST_ADDR || avs_address == IRQ_MK_ADDR
		|| avs_address == SYS_ST_ADDR || avs_address == WAKE_ADDR;
	assign wr_pwr_ctl = avs_write && avs_byteenable[0] && avs_address == PWR_CTL_ADDR;
	assign wr_wd_ctl  = avs_write && avs_byteenable[0] && avs_address == WD_CTL_ADDR;
	assign wr_st   = avs_write && avs_byteenable[0] && avs_address == IRQ_ST_ADDR;
	assign wr_mk   = avs_write && avs_byteenable[0] && avs_address == IRQ_MK_ADDR;
	// Unmapped access answers with the slave-error code
	assign avs_response = (avs_read || avs_write) && !mapped ? 2'b10 : 2'b00;

	// Read mux; unmapped and write-only addresses read as zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			PWR_CTL_ADDR: rd_mux = {24'h000000, pwr_ctl_q};
			WD_CTL_ADDR:  rd_mux = {24'h000000, wd_ctl_q};
			IRQ_ST_ADDR:  rd_mux = {28'h0000000, irq_st_q};
			IRQ_MK_ADDR:  rd_mux = {28'h0000000, irq_mk_q};
			SYS_ST_ADDR:  rd_mux = {18'h00000, wdt_cnt_q};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait state on every read so that read data leaves a flip-flop;
	// costs a cycle per read, but keeps the mux off the bus timing path.
	// Writes still complete with no wait state.
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rd_ack_q <= 1'b0;
		else
			rd_ack_q <= avs_read && !rd_ack_q;
	end

	// Read data register, loaded in the wait cycle and held afterwards
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !rd_ack_q)
			avs_readdata <= rd_mux;
	end
	assign avs_waitrequest = avs_read && !rd_ack_q;

	// Watchdog runs when enabled and not halted by idle or power-down
	assign wdt_run = wd_ctl_q[WDT_ENABLE_BIT]
		&& (mode_q == MODE_RUN
		|| (mode_q == MODE_IDLE && wd_ctl_q[WDT_RUN_IN_SLEEP_BIT]));
	// Prescaler wraps at ratio minus one, which gives one counter step per ratio
	assign presc_tick = wdt_run && mc_tick
		&& (presc_q == PRESC_W'((1 << presc_exp(wd_ctl_q[PS_HI:PS_LO])) - 1));
	assign wdt_timeout = presc_tick && (&wdt_cnt_q);

	// Prescaler: one step per machine cycle
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			presc_q <= '0;
		else if (srst_req || wd_clear_pend_q && mc_tick)
			presc_q <= '0;
		else if (presc_tick)
			presc_q <= '0;
		else if (wdt_run && mc_tick)
			presc_q <= presc_q + PRESC_W'(1);
	end

	// Fourteen-bit watchdog counter
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			wdt_cnt_q <= '0;
		else if (srst_req || wd_clear_pend_q && mc_tick)
			wdt_cnt_q <= '0;
		else if (presc_tick)
			wdt_cnt_q <= wdt_cnt_q + WDT_BITS'(1);
	end

	// Clear request waits for the next instruction-cycle boundary; a second
	// write before that boundary simply keeps the request pending
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			wd_clear_pend_q <= 1'b0;
		else if (wr_wd_ctl && avs_writedata[WDT_CLEAR_BIT])
			wd_clear_pend_q <= 1'b1;
		else if (mc_tick || srst_req)
			wd_clear_pend_q <= 1'b0;
	end

	// Watchdog control register; bits 4:3 are not built and read as zero
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			wd_ctl_q <= WD_CTL_RESET;
		else if (srst_req)
			wd_ctl_q <= WD_CTL_RESET;
		else if (wr_wd_ctl)
			wd_ctl_q <= avs_writedata[7:0] & 8'hE7;
		else if (wd_clear_pend_q && mc_tick)
			wd_ctl_q[WDT_CLEAR_BIT] <= 1'b0;
	end

	// System reset stretcher: pin or watchdog reloads the count, so the pulse ends 24 cycles after the last trigger
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			srst_cnt_q <= 5'(SYS_RST_CYCLES);
		else if (pin_rst || (wdt_timeout && wd_ctl_q[WDT_ENABLE_BIT]))
			srst_cnt_q <= 5'(SYS_RST_CYCLES);
		else if (srst_cnt_q != 5'h00)
			srst_cnt_q <= srst_cnt_q - 5'h01;
	end
	assign srst_req  = (srst_cnt_q != 5'h00);
	assign sys_reset = srst_req;

	// Power-on flag set once after the power-on reset releases
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			por_done_q <= 1'b0;
		else
			por_done_q <= 1'b1;
	end

	// Power control register; idle and power-down cleared on exit
	assign wake_ev = wake_irq && mode_q == MODE_IDLE;
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			pwr_ctl_q <= PWR_CTL_RESET;
		else if (!por_done_q)
			pwr_ctl_q[POWER_ON_FLAG_BIT] <= 1'b1;
		else if (srst_req)
			// Warm reset keeps the power-on flag so software can tell the two apart
			pwr_ctl_q <= {3'b000, pwr_ctl_q[POWER_ON_FLAG_BIT], 4'h0};
		else
		begin
			// A wake in the same cycle as a write wins for the idle bit
			if (wr_pwr_ctl)
				pwr_ctl_q <= avs_writedata[7:0] & 8'h1F;
			if (wake_ev)
				pwr_ctl_q[LIGHT_SLEEP_BIT] <= 1'b0;
		end
	end

	// Mode machine
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			mode_q <= MODE_RUN;
		else if (srst_req)
			mode_q <= MODE_RUN;
		else
		begin
			unique case (mode_q)
				MODE_RUN:
					if (pwr_ctl_q[POWERDOWN_BIT])
						mode_q <= MODE_POWDN;
					else if (pwr_ctl_q[LIGHT_SLEEP_BIT])
						mode_q <= MODE_IDLE;
				MODE_IDLE:
					if (wake_irq)
						mode_q <= MODE_RUN;
					else if (pwr_ctl_q[POWERDOWN_BIT])
						mode_q <= MODE_POWDN;
				MODE_POWDN:
					mode_q <= MODE_POWDN;
				default:
					mode_q <= MODE_RUN;
			endcase
		end
	end

	// Clock enables toward the core and peripherals
	assign core_clk_en   = (mode_q == MODE_RUN) && osc_half_q;
	assign periph_clk_en = (mode_q != MODE_POWDN) && osc_half_q;
	assign osc_run       = (mode_q != MODE_POWDN);

	// Reset values presented to the rest of the core
	assign port_reset_val = PORT_RESET;
	assign sp_reset_val   = SP_RESET;
	assign sfr_reset_val  = SFR_RESET;

	// Interrupt events, one per status bit
	assign ev_set = {mode_q == MODE_RUN && pwr_ctl_q[POWERDOWN_BIT] && !srst_req,
		wake_ev, pin_rst, wdt_timeout && wd_ctl_q[WDT_ENABLE_BIT]};

	// Sticky status bits; set wins over a write-one clear so that an event
	// arriving during the clear is never lost
	for (genvar i = 0; i < EV_W; i++)
	begin : g_status
		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
				irq_st_q[i] <= 1'b0;
			else if (ev_set[i])
				irq_st_q[i] <= 1'b1;
			else if (wr_st && avs_writedata[i])
				irq_st_q[i] <= 1'b0;
		end
	end

	// Mask register, same layout
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_mk_q <= '0;
		else if (wr_mk)
			irq_mk_q <= avs_writedata[EV_W-1:0];
	end
	assign irq = |(irq_st_q & irq_mk_q);
endmodule : watchdog_power_reset_control

/* File: hdl/wdt_pm_pkg.sv */
// Package: offsets, field positions, reset values and timing counts
package wdt_pm_pkg;
	// Register byte addresses (printed offsets are not multiples of four: index times four)
	localparam logic [7:0] PWR_CTL_INDEX = 8'h87;
	localparam logic [7:0] WD_CTL_INDEX  = 8'h8F;
	localparam logic [7:0] IRQ_ST_INDEX = 8'hA0;
	localparam logic [7:0] IRQ_MK_INDEX = 8'hA1;
	localparam logic [7:0] SYS_ST_INDEX = 8'hA2;
	localparam logic [7:0] WAKE_INDEX   = 8'hA3;
	localparam int         ADDR_W       = 10;
	localparam logic [ADDR_W-1:0] PWR_CTL_ADDR = {PWR_CTL_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] WD_CTL_ADDR  = {WD_CTL_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_ST_ADDR = {IRQ_ST_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] IRQ_MK_ADDR = {IRQ_MK_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] SYS_ST_ADDR = {SYS_ST_INDEX, 2'b00};
	localparam logic [ADDR_W-1:0] WAKE_ADDR   = {WAKE_INDEX, 2'b00};
	// Power control fields
	localparam int POWER_ON_FLAG_BIT    = 4;
	localparam int USER_FLAG_ONE_BIT    = 3;
	localparam int USER_FLAG_ZERO_BIT   = 2;
	localparam int POWERDOWN_BIT        = 1;
	localparam int LIGHT_SLEEP_BIT      = 0;
	// Watchdog control fields
	localparam int WDT_ENABLE_BIT       = 7;
	localparam int WDT_CLEAR_BIT        = 6;
	localparam int WDT_RUN_IN_SLEEP_BIT = 5;
	localparam int PS_HI    = 2;
	localparam int PS_LO    = 0;
	// Interrupt status bits
	localparam int EV_WDT   = 0;
	localparam int EV_RST   = 1;
	localparam int EV_IDLE  = 2;
	localparam int EV_PD    = 3;
	localparam int EV_W     = 4;
	// Reset values
	localparam logic [7:0] PWR_CTL_RESET = 8'h00;
	localparam logic [7:0] WD_CTL_RESET  = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [7:0] SP_RESET   = 8'h07;
	localparam logic [7:0] SFR_RESET  = 8'h00;
	// Timing
	localparam int OSC_PER_MC     = 12;
	localparam int CORE_DIV       = 2;
	localparam int WDT_BITS       = 14;
	localparam int RST_HOLD_MC    = 2;
	localparam int RST_PHASE      = 9;
	localparam int SYS_RST_CYCLES = 24;
endpackage : wdt_pm_pkg

/* File: verif/wdt_pm_checker.sv */
// Checker for watchdog, power and reset control ports
module wdt_pm_checker
	import wdt_pm_pkg::*;
#(
	parameter int PRESC_W = 8
)
(
	// Clock and reset
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	// Pins and bus
	input wire logic                          reset_pin,
	input wire logic                          wake_irq,
	input wire logic [wdt_pm_pkg::ADDR_W-1:0] avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [3:0]                    avs_byteenable,
	input wire logic [31:0]                   avs_writedata,
	input wire logic [31:0]                   avs_readdata,
	input wire logic                          avs_waitrequest,
	// Clock gating and reset
	input wire logic                          core_clk_en,
	input wire logic                          periph_clk_en,
	input wire logic                          osc_run,
	input wire logic                          sys_reset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Accepted power control write setting one bit
	sequence s_pwr_ctl_set(b);
		avs_write && avs_byteenable[0] && avs_address == PWR_CTL_ADDR && avs_writedata[b]
			&& !sys_reset;
	endsequence
	// One-cycle pulse on a quiet reset pin
	sequence s_glitch;
		!reset_pin [*8] ##1 reset_pin && osc_run && !sys_reset ##1 !reset_pin;
	endsequence
	a_div_two: assert property (periph_clk_en |=> !periph_clk_en)
		else $error("peripheral enable held two cycles");
	a_periph_runs: assert property (periph_clk_en |-> ##2 (periph_clk_en || !osc_run || sys_reset))
		else $error("peripheral enable stopped while oscillator runs");
	a_core_idle: assert property (s_pwr_ctl_set(LIGHT_SLEEP_BIT) && !wake_irq |-> ##2 !core_clk_en [*6])
		else $error("core enable pulsed in idle");
	a_wake_idle: assert property ($rose(wake_irq) && osc_run && !sys_reset |-> ##[1:4] core_clk_en)
		else $error("core enable not back after wake");
	a_osc_stops: assert property (s_pwr_ctl_set(POWERDOWN_BIT) && !reset_pin |-> ##2 !osc_run)
		else $error("oscillator still running in power-down");
	a_wd_ctl_reset: assert property (avs_read && !avs_waitrequest && avs_address == WD_CTL_ADDR
		&& $past(sys_reset, 2) |-> avs_readdata[7:0] == 8'h00)
		else $error("watchdog control not cleared during reset");
	a_sysrst_hold: assert property ($rose(sys_reset) |-> sys_reset [*8])
		else $error("system reset too short");
	a_glitch_free: assert property (s_glitch |-> !sys_reset [*8])
		else $error("reset pin glitch caused a reset");
endmodule : wdt_pm_checker

bind watchdog_power_reset_control wdt_pm_checker #(.PRESC_W(PRESC_W)) chk_u (
	.ref_clk(ref_clk), .rst_b(rst_b), .reset_pin(reset_pin), .wake_irq(wake_irq),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
	.sys_reset(sys_reset));

/* File: verif/watchdog_power_reset_control_tb_top.sv */
// Self-checking bench for watchdog, power and reset control
module watchdog_power_reset_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pm_pkg::*;
	typedef struct {logic [33:0] v; logic [7:0] t;} note_type;
	logic              ref_clk, rst_b, reset_pin, wake_irq, avs_read, avs_write;
	logic [ADDR_W-1:0] avs_address;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_writedata, avs_readdata, rng, r;
	logic [1:0]        avs_response;
	logic              avs_waitrequest, core_clk_en, periph_clk_en, osc_run, sys_reset, irq;
	logic [7:0]        port_reset_val, sp_reset_val, sfr_reset_val;
	logic [33:0]       got;
	note_type          e;
	note_type          exp_q[$];
	int                err_total, checks_done;
	watchdog_power_reset_control dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reset_pin(reset_pin),
		.wake_irq(wake_irq), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
		.osc_run(osc_run), .sys_reset(sys_reset), .port_reset_val(port_reset_val),
		.sp_reset_val(sp_reset_val), .sfr_reset_val(sfr_reset_val), .irq(irq));
	// Clock, 100 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	task automatic chk(input logic [33:0] g, input logic [33:0] x);
		checks_done++;
		if (g !== x)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		n = 0;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 100);
		if (n >= 100)
			err_total++;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] v, input logic [7:0] t);
		exp_q.push_back('{v, t});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic waitsys();
		repeat (200) if (sys_reset !== 1'b0) @(posedge ref_clk);
	endtask : waitsys
	task automatic pin(input int w);
		@(posedge ref_clk) reset_pin <= 1'b1;
		repeat (w) @(posedge ref_clk);
		reset_pin <= 1'b0;
	endtask : pin
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	// Read monitor; a tolerance covers machine-cycle phase
	always @(posedge ref_clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
		begin
			e = exp_q.pop_front();
			got = {avs_response, avs_readdata};
			if (got[13:0] + e.t >= e.v[13:0] && got[13:0] <= e.v[13:0] + e.t)
				got[13:0] = e.v[13:0];
			chk(got, e.v);
		end
	// Hang guard, well above the expected run length
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		final_report();
	end
	// Main sequence
	initial
	begin
		{rst_b, reset_pin, wake_irq, avs_read, avs_write} = 5'h00;
		{avs_address, avs_writedata, avs_byteenable, rng} = {10'h000, 32'h0, 4'h1, 32'h705F};
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(WD_CTL_ADDR, 34'h0, 8'h0);
		waitsys();
		rd(PWR_CTL_ADDR, 34'h10, 8'h0);
		chk({port_reset_val, sp_reset_val, sfr_reset_val}, 34'hFF0700);
		$display("test reset done");
		repeat (4)
		begin
			r = xs();
			bus(1'b1, PWR_CTL_ADDR, r & 32'h0C);
			rd(PWR_CTL_ADDR, r & 32'h0C, 8'h0);
			bus(1'b1, WD_CTL_ADDR, r & 32'h27);
			rd(WD_CTL_ADDR, r & 32'h27, 8'h0);
		end
		repeat (300) @(posedge ref_clk);
		rd(SYS_ST_ADDR, 34'h0, 8'h0);
		rd(10'h3FC, 34'h2_0000_0000, 8'h0);
		$display("test registers done");
		// Idle halts the watchdog; wake clears idle and raises the event
		bus(1'b1, IRQ_MK_ADDR, 32'h1 << EV_IDLE);
		bus(1'b1, PWR_CTL_ADDR, (r & 32'h0C) | (32'h1 << LIGHT_SLEEP_BIT));
		bus(1'b1, WD_CTL_ADDR, 32'hC0);
		repeat (240) @(posedge ref_clk);
		rd(SYS_ST_ADDR, 34'h0, 8'h0);
		chk(irq, 1'b0);
		@(posedge ref_clk) wake_irq <= 1'b1;
		repeat (2) @(posedge ref_clk);
		wake_irq <= 1'b0;
		rd(PWR_CTL_ADDR, r & 32'h0C, 8'h0);
		chk(irq, 1'b1);
		bus(1'b1, IRQ_MK_ADDR, 32'h0);
		@(negedge ref_clk) chk(irq, 1'b0);
		bus(1'b1, IRQ_MK_ADDR, 32'h1 << EV_IDLE);
		bus(1'b1, IRQ_ST_ADDR, 32'hFF);
		@(negedge ref_clk) chk(irq, 1'b0);
		$display("test idle done");
		// Counting rate, clear bit and every prescale code
		bus(1'b1, WD_CTL_ADDR, 32'hC0);
		repeat (480) @(posedge ref_clk);
		rd(SYS_ST_ADDR, 34'd20, 8'h2);
		rd(WD_CTL_ADDR, 34'h80, 8'h0);
		for (int c = 0; c < 8; c++)
		begin
			bus(1'b1, WD_CTL_ADDR, 32'hC0 | c);
			// Codes 1 and 2 swap ratios 8 and 4; the wait gives four counter steps
			repeat (96 << ((c < 4) ? {c[0], c[1]} : c)) @(posedge ref_clk);
			rd(SYS_ST_ADDR, 34'h4, 8'h1);
		end
		$display("test prescale done");
		// Short pin pulses are ignored; a long one ends power-down
		for (int w = 1; w < 4; w += 2)
		begin
			pin(w);
			repeat (60) @(posedge ref_clk);
			chk(sys_reset, 1'b0);
		end
		bus(1'b1, PWR_CTL_ADDR, 32'h1 << POWERDOWN_BIT);
		repeat (4) @(posedge ref_clk);
		chk(osc_run, 1'b0);
		pin(40);
		waitsys();
		rd(PWR_CTL_ADDR, 34'h0, 8'h0);
		rd(WD_CTL_ADDR, 34'h0, 8'h0);
		$display("test powerdown done");
		final_report();
	end
endmodule : watchdog_power_reset_control_tb_top
